//--- adc_offset_chop_delay_ctrl.sv
// Control logic of a 10-bit converter: chopping, mute, trims, delays.
// Assumes the analog core returns its code on analog_code after a start pulse.
//
// What this block does
// - Chop bit runs paired opposite-sign conversions
// - Mid-scale zero point between 1FF and 200
// - Mute ties converter input to centre scale
// - Sign bit inverts converter input and output
// - Chop pair sums to 11 bits, LSB dropped
// - Battery channel forces attenuator on
// - Conversion takes about one short cycle
// - Counter starts with trigger, stops when done
// - Clearing delay enable resets the counter
// - Trigger bit clears when conversion is ready
// - Sampling tracks input; conversion start ends sampling
//
// Added by the designer: strobed register access and the placing of the registers.
module adc_offset_chop_delay_ctrl
    import adc_ctrl_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic [ADDR_W-1:0] addr, // Register byte address
    input wire logic [DATA_W-1:0] wdata, // Write data
    input wire logic we, // Write strobe
    input wire logic re, // Read strobe
    output logic [DATA_W-1:0] rdata, // Read data, cycle after re
    input wire logic [CODE_W-1:0] analog_code, // Raw code from analog core
    output logic regulator_on, // Regulator enable to analog
    output logic sampling_on, // Sampling enable to analog
    output logic convert_start, // One-cycle conversion start pulse
    output logic mute_to_analog, // Input mute to analog
    output logic sign_to_analog, // Input inversion to analog
    output logic attenuator_on, // Attenuator enable to analog
    output logic single_ended_to_analog, // Single-ended mode to analog
    output logic [CHAN_W-1:0] channel_to_analog, // Channel select to analog
    output logic [CODE_W-1:0] trim_pos_to_analog, // Positive offset trim
    output logic [CODE_W-1:0] trim_neg_to_analog // Negative offset trim
);

    // Software control state
    logic regulator_enable; // Regulator request
    logic sampling_enable; // Sampling request
    logic conversion_trigger; // Conversion request, cleared when done
    logic chop_enable; // Chopped operation
    logic input_mute; // Input to centre scale
    logic sign_invert; // Input and output inversion
    logic single_ended_select; // Single-ended when 1
    logic [CHAN_W-1:0] channel_select; // Input channel
    logic attenuator_enable; // Attenuator request
    logic delay_counter_enable; // Delay counter enable
    logic [CODE_W-1:0] offset_trim_positive; // Positive trim
    logic [CODE_W-1:0] offset_trim_negative; // Negative trim
    logic [DLY_W-1:0] dly_regulator; // Regulator delay, cycles
    logic [DLY_W-1:0] dly_sampling; // Sampling delay, cycles
    logic [DLY_W-1:0] dly_trigger; // Trigger delay, cycles

    // Results and sequencer state
    logic [CODE_W-1:0] conversion_result; // Last result
    logic [SUM_W-1:0] chop_sum; // Last chopped 11-bit sum
    logic [CODE_W-1:0] first_code; // First half of a chop pair
    conv_state_type state; // Sequencer state
    conv_state_type next_state; // Sequencer next state
    logic [WAIT_W-1:0] wait_cnt; // Cycles spent in conversion
    logic chop_phase; // Second half of a chop pair
    logic [DLY_W-1:0] delay_count; // Delay counter value
    logic counting; // Delay counter running
    logic delay_started; // Counter started since enable
    logic [SETTLE_W-1:0] settle_cnt; // Cycles since last control write, saturating
    logic [CODE_W-1:0] code_sync; // Synchronised analog code

    // Decoded strobes and helpers
    logic wr_main; // Write to main control
    logic wr_second; // Write to second control
    logic trigger_set; // Software writes trigger high
    logic start_req; // Accepted conversion request
    logic half_done; // Last cycle of one conversion
    logic conv_done; // Whole conversion finished
    logic eff_sign; // Sign applied to current conversion
    logic eff_atten; // Attenuator after battery forcing
    logic [CODE_W-1:0] corrected; // Code after output inversion
    logic [SUM_W-1:0] pair_sum; // Sum of a chop pair
    logic [DATA_W-1:0] read_mux; // Read data selection

    // Bring the analog code into the clock domain
    input_sync #(
        .WIDTH(CODE_W)
    ) u_code_sync (
        .clk(clk),
        .srst(srst),
        .din(analog_code),
        .dout(code_sync)
    );

    // Address decode and conversion bookkeeping
    assign wr_main = we && (addr == OFF_CONTROL_MAIN);
    assign wr_second = we && (addr == OFF_CONTROL_SECOND);
    assign trigger_set = wr_main && wdata[BIT_TRIGGER];
    assign start_req = trigger_set && !conversion_trigger && (state == st_sample);
    assign half_done = (state == st_convert) && (wait_cnt == WAIT_W'(CAPTURE_CYCLES - 1));
    assign conv_done = half_done && (!chop_enable || chop_phase);
    assign eff_sign = sign_invert ^ chop_phase;
    assign eff_atten = attenuator_enable || (channel_select == BATTERY_CHANNEL);
    assign corrected = eff_sign ? (CODE_FULL - code_sync) : code_sync;
    assign pair_sum = SUM_W'(first_code) + SUM_W'(corrected);

    // Sequencer next state
    always_comb begin
        next_state = state;
        unique case (state)
            st_sample: begin
                if (start_req) begin
                    next_state = delay_counter_enable ? st_delay : st_convert;
                end
            end
            st_delay: begin
                // Leave on reaching the delay, the 32 us cap, or a counter reset
                if (!delay_counter_enable || delay_count >= dly_trigger ||
                        delay_count == DLY_W'(DELAY_MAX_CYCLES)) begin
                    next_state = st_convert;
                end
            end
            st_convert: begin
                if (conv_done) begin
                    next_state = st_sample;
                end else if (half_done) begin
                    next_state = st_resample;
                end
            end
            st_resample: begin
                next_state = st_convert;
            end
        endcase
    end

    // Sequencer state, conversion timer and chop phase
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= st_sample;
            wait_cnt <= '0;
            chop_phase <= 1'b0;
            convert_start <= 1'b0;
        end else begin
            state <= next_state;
            convert_start <= (next_state == st_convert) && (state != st_convert);
            if (state == st_convert) begin
                wait_cnt <= wait_cnt + WAIT_W'(1);
            end else begin
                wait_cnt <= '0;
            end
            if (conv_done) begin
                chop_phase <= 1'b0;
            end else if (half_done) begin
                chop_phase <= 1'b1;
            end
        end
    end

    // Result capture, plain or chopped
    always_ff @(posedge clk) begin
        if (srst) begin
            conversion_result <= MID_HIGH;
            chop_sum <= SUM_MID;
            first_code <= MID_LOW;
        end else if (half_done) begin
            if (!chop_phase && chop_enable) begin
                first_code <= corrected; // First half of the pair
            end else if (chop_enable) begin
                chop_sum <= pair_sum;
                conversion_result <= pair_sum[SUM_W-1:1];
            end else begin
                conversion_result <= corrected;
            end
        end
    end

    // Main control register; a software set beats the hardware clear
    always_ff @(posedge clk) begin
        if (srst) begin
            regulator_enable <= 1'b0;
            sampling_enable <= 1'b0;
            conversion_trigger <= 1'b0;
            chop_enable <= 1'b0;
            input_mute <= 1'b0;
            sign_invert <= 1'b0;
            single_ended_select <= 1'b0;
            channel_select <= CHAN_RESET;
        end else if (wr_main) begin
            regulator_enable <= wdata[BIT_REGULATOR];
            sampling_enable <= wdata[BIT_SAMPLING];
            conversion_trigger <= wdata[BIT_TRIGGER] || (conversion_trigger && !conv_done);
            chop_enable <= wdata[BIT_CHOP];
            input_mute <= wdata[BIT_MUTE];
            sign_invert <= wdata[BIT_SIGN];
            single_ended_select <= wdata[BIT_SINGLE];
            channel_select <= wdata[CHAN_LSB +: CHAN_W];
        end else if (conv_done) begin
            conversion_trigger <= 1'b0;
        end
    end

    // Second control, trims and delay settings
    always_ff @(posedge clk) begin
        if (srst) begin
            attenuator_enable <= 1'b0;
            delay_counter_enable <= 1'b0;
            offset_trim_positive <= TRIM_RESET;
            offset_trim_negative <= TRIM_RESET;
            dly_regulator <= DLY_REG_RESET;
            dly_sampling <= DLY_SAMP_RESET;
            dly_trigger <= DLY_TRIG_RESET;
        end else if (we) begin
            if (wr_second) begin
                attenuator_enable <= wdata[BIT_ATTEN];
                delay_counter_enable <= wdata[BIT_DELAY_EN];
            end
            if (addr == OFF_TRIM_POS) begin
                offset_trim_positive <= wdata[CODE_W-1:0];
            end
            if (addr == OFF_TRIM_NEG) begin
                offset_trim_negative <= wdata[CODE_W-1:0];
            end
            if (addr == OFF_DELAY_A) begin
                dly_regulator <= wdata[DLY_REG_LSB +: DLY_W];
                dly_sampling <= wdata[DLY_SAMP_LSB +: DLY_W];
            end
            if (addr == OFF_DELAY_B) begin
                dly_trigger <= wdata[DLY_TRIG_LSB +: DLY_W];
            end
        end
    end

    // Delay counter: runs from trigger to conversion end, capped at 32 us
    always_ff @(posedge clk) begin
        if (srst || !delay_counter_enable) begin
            delay_count <= '0;
            counting <= 1'b0;
            delay_started <= 1'b0;
        end else begin
            if (start_req) begin
                counting <= 1'b1;
                delay_started <= 1'b1;
            end else if (conv_done) begin
                counting <= 1'b0;
            end
            if (counting && (delay_count < DLY_W'(DELAY_MAX_CYCLES))) begin
                delay_count <= delay_count + DLY_W'(1);
            end
        end
    end

    // Settling timer, restarted by any write to either control register
    always_ff @(posedge clk) begin
        if (srst || wr_main || wr_second) begin
            settle_cnt <= '0;
        end else if (settle_cnt < SETTLE_W'(SETTLE_CYCLES)) begin
            settle_cnt <= settle_cnt + SETTLE_W'(1);
        end
    end

    // Analog controls; regulator and sampling each gated by its delay when the counter is used
    always_ff @(posedge clk) begin
        if (srst) begin
            regulator_on <= 1'b0;
            sampling_on <= 1'b0;
            mute_to_analog <= 1'b0;
            sign_to_analog <= 1'b0;
            attenuator_on <= 1'b0;
            single_ended_to_analog <= 1'b0;
            channel_to_analog <= CHAN_RESET;
            trim_pos_to_analog <= TRIM_RESET;
            trim_neg_to_analog <= TRIM_RESET;
        end else begin
            regulator_on <= regulator_enable &&
                (!delay_counter_enable || (delay_started && delay_count >= dly_regulator));
            sampling_on <= sampling_enable && (state != st_convert) &&
                (!delay_counter_enable || (delay_started && delay_count >= dly_sampling));
            mute_to_analog <= input_mute;
            sign_to_analog <= eff_sign;
            attenuator_on <= eff_atten;
            single_ended_to_analog <= single_ended_select;
            channel_to_analog <= channel_select;
            trim_pos_to_analog <= offset_trim_positive;
            trim_neg_to_analog <= offset_trim_negative;
        end
    end

    // Read selection; unmapped addresses read zero
    always_comb begin
        read_mux = '0;
        unique case (addr)
            OFF_CONTROL_MAIN: begin
                read_mux[BIT_REGULATOR] = regulator_enable;
                read_mux[BIT_SAMPLING] = sampling_enable;
                read_mux[BIT_TRIGGER] = conversion_trigger;
                read_mux[BIT_CHOP] = chop_enable;
                read_mux[BIT_MUTE] = input_mute;
                read_mux[BIT_SIGN] = sign_invert;
                read_mux[BIT_SINGLE] = single_ended_select;
                read_mux[CHAN_LSB +: CHAN_W] = channel_select;
            end
            OFF_CONTROL_SECOND: begin
                read_mux[BIT_ATTEN] = eff_atten;
                read_mux[BIT_DELAY_EN] = delay_counter_enable;
            end
            OFF_TRIM_POS: read_mux[CODE_W-1:0] = offset_trim_positive;
            OFF_TRIM_NEG: read_mux[CODE_W-1:0] = offset_trim_negative;
            OFF_DELAY_A: begin
                read_mux[DLY_REG_LSB +: DLY_W] = dly_regulator;
                read_mux[DLY_SAMP_LSB +: DLY_W] = dly_sampling;
            end
            OFF_DELAY_B: read_mux[DLY_TRIG_LSB +: DLY_W] = dly_trigger;
            OFF_RESULT: read_mux[CODE_W-1:0] = conversion_result;
            OFF_CHOP_SUM: read_mux[SUM_W-1:0] = chop_sum;
            OFF_STATUS: begin
                read_mux[ST_BUSY] = (state != st_sample);
                read_mux[ST_PHASE] = chop_phase;
                read_mux[ST_SETTLED] = (settle_cnt == SETTLE_W'(SETTLE_CYCLES));
                read_mux[ST_COUNT_LSB +: DLY_W] = delay_count;
            end
            default: read_mux = '0;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= '0;
        end else begin
            rdata <= re ? read_mux : '0;
        end
    end

endmodule : adc_offset_chop_delay_ctrl

//--- adc_ctrl_pkg.sv
// Shared constants and types of the converter control block.
// Assumes a single 10 MHz system clock and a plain register port.
package adc_ctrl_pkg;

    // Bus and data widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CODE_W = 10;
    localparam int SUM_W = 11;
    localparam int CHAN_W = 3;
    localparam int DLY_W = 9;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CONTROL_MAIN = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CONTROL_SECOND = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_TRIM_POS = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_TRIM_NEG = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_DELAY_A = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_DELAY_B = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_RESULT = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_CHOP_SUM = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h20;

    // Main control fields
    localparam int BIT_REGULATOR = 0;
    localparam int BIT_SAMPLING = 1;
    localparam int BIT_TRIGGER = 2;
    localparam int BIT_CHOP = 3;
    localparam int BIT_MUTE = 4;
    localparam int BIT_SIGN = 5;
    localparam int BIT_SINGLE = 6;
    localparam int CHAN_LSB = 8;

    // Second control fields
    localparam int BIT_ATTEN = 0;
    localparam int BIT_DELAY_EN = 1;

    // Delay setting fields
    localparam int DLY_REG_LSB = 0;
    localparam int DLY_SAMP_LSB = 16;
    localparam int DLY_TRIG_LSB = 0;

    // Status fields
    localparam int ST_BUSY = 0;
    localparam int ST_PHASE = 1;
    localparam int ST_SETTLED = 2;
    localparam int ST_COUNT_LSB = 16;

    // Reset values
    localparam logic [CODE_W-1:0] TRIM_RESET = 10'h200;
    localparam logic [DLY_W-1:0] DLY_REG_RESET = 9'h000;
    localparam logic [DLY_W-1:0] DLY_SAMP_RESET = 9'h00A;
    localparam logic [DLY_W-1:0] DLY_TRIG_RESET = 9'h014;
    localparam logic [CHAN_W-1:0] CHAN_RESET = 3'h0;

    // Channel code of the battery monitor input
    localparam logic [CHAN_W-1:0] BATTERY_CHANNEL = 3'h4;

    // Code landmarks: mid-scale lies between the two middle codes
    localparam logic [CODE_W-1:0] MID_LOW = 10'h1FF;
    localparam logic [CODE_W-1:0] MID_HIGH = 10'h200;
    localparam logic [CODE_W-1:0] CODE_FULL = 10'h3FF;
    localparam logic [SUM_W-1:0] SUM_MID = 11'h3FF;

    // Timing, in picoseconds, and derived cycle counts
    localparam int CLK_PERIOD_PS = 100_000;
    localparam int CONV_TIME_PS = 62_500;
    localparam int CONV_CYCLES = (CONV_TIME_PS / CLK_PERIOD_PS < 1) ? 1 : CONV_TIME_PS / CLK_PERIOD_PS;
    localparam int SYNC_STAGES = 3;
    localparam int CAPTURE_CYCLES = CONV_CYCLES + SYNC_STAGES;
    localparam int SETTLE_TIME_PS = 1_000_000;
    localparam int SETTLE_CYCLES = (SETTLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DELAY_MAX_TIME_PS = 32_000_000;
    localparam int DELAY_MAX_CYCLES = DELAY_MAX_TIME_PS / CLK_PERIOD_PS;
    localparam int WAIT_W = 4;
    localparam int SETTLE_W = 5;

    // Conversion sequencer states
    typedef enum logic [1:0] {
        st_sample,
        st_delay,
        st_convert,
        st_resample
    } conv_state_type;

endpackage : adc_ctrl_pkg

//--- input_sync.sv
// Three-stage synchroniser for a bus from the analog core.
// Assumes each bit may change at any time relative to clk.
module input_sync #(
    parameter int WIDTH = 10
) (
    input wire logic clk, // System clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic [WIDTH-1:0] din, // Unsynchronised input
    output logic [WIDTH-1:0] dout // Filtered, synchronised output
);

    // One chain per bit; a change counts once stages two and three agree
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic s1; // First stage, read only by the second
        logic s2; // Second stage
        logic s3; // Third stage

        always_ff @(posedge clk) begin
            if (srst) begin
                s1 <= 1'b0;
                s2 <= 1'b0;
                s3 <= 1'b0;
                dout[i] <= 1'b0;
            end else begin
                s1 <= din[i];
                s2 <= s1;
                s3 <= s2;
                if (s2 == s3) begin
                    dout[i] <= s3;
                end
            end
        end
    end

endmodule : input_sync

//--- adc_ctrl_monitor.sv
// Concurrent checks on the converter control block's ports.
// Assumes it is bound to the top module and sees only its ports.
module adc_ctrl_monitor
    import adc_ctrl_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic srst, // Sync reset
    input wire logic [ADDR_W-1:0] addr, // Byte address
    input wire logic [DATA_W-1:0] wdata, // Write data
    input wire logic we, // Write strobe
    input wire logic re, // Read strobe
    input wire logic [DATA_W-1:0] rdata, // Read data
    input wire logic convert_start, // Start pulse
    input wire logic sampling_on, // Sampling enable
    input wire logic mute_to_analog, // Mute
    input wire logic attenuator_on, // Attenuator
    input wire logic [CHAN_W-1:0] channel_to_analog, // Channel
    input wire logic [CODE_W-1:0] trim_pos_to_analog, // Positive trim
    input wire logic [CODE_W-1:0] trim_neg_to_analog // Negative trim
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic [CODE_W-1:0] trim_seen; // Last positive trim written
    // Track positive trim writes
    always_ff @(posedge clk) begin
        if (srst) trim_seen <= TRIM_RESET;
        else if (we && addr == OFF_TRIM_POS) trim_seen <= wdata[CODE_W-1:0];
    end
    sequence main_write;
        we && addr == OFF_CONTROL_MAIN;
    endsequence
    sequence trig_write;
        main_write ##0 wdata[BIT_TRIGGER];
    endsequence
    AST_RDATA_IDLE: assert property (!$past(re) |-> rdata == 32'h0) else $error("rdata not zero");
    AST_UNMAPPED: assert property (re && addr == 8'h40 |=> rdata == 32'h0) else $error("unmapped read");
    AST_TRIM_RESET: assert property ($fell(srst) |-> trim_pos_to_analog == TRIM_RESET
        && trim_neg_to_analog == TRIM_RESET) else $error("trim reset");
    AST_TRIM_WRITE: assert property (we && addr == OFF_TRIM_POS ##2 1'b1 |-> trim_pos_to_analog == trim_seen)
        else $error("trim output");
    AST_MUTE_ON: assert property (main_write ##0 wdata[BIT_MUTE] |-> ##[1:2] mute_to_analog)
        else $error("mute output");
    AST_START_PULSE: assert property (convert_start |=> !convert_start) else $error("start pulse");
    AST_TRIG_START: assert property (trig_write |-> ##[1:400] convert_start) else $error("no start");
    AST_SAMPLE_OFF: assert property (convert_start |=> !sampling_on) else $error("sampling on");
    AST_BATTERY: assert property (channel_to_analog == BATTERY_CHANNEL && $stable(channel_to_analog)
        |-> attenuator_on) else $error("battery attenuator");
endmodule : adc_ctrl_monitor

bind adc_offset_chop_delay_ctrl adc_ctrl_monitor mon (.clk, .srst, .addr, .wdata, .we, .re, .rdata,
    .convert_start, .sampling_on, .mute_to_analog, .attenuator_on, .channel_to_analog,
    .trim_pos_to_analog, .trim_neg_to_analog);

//--- adc_offset_chop_delay_ctrl_bench.sv
// Self-checking bench for the converter control block.
// Assumes a fixed analog code from the core and the package's register map.
module adc_offset_chop_delay_ctrl_bench
    import adc_ctrl_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, srst = 1, we = 0, re = 0; // Clock, reset, strobes
    logic [ADDR_W-1:0] addr = '0; // Bus address
    logic [DATA_W-1:0] wdata = '0, rdata; // Bus data
    logic [CODE_W-1:0] analog_code = 10'h203; // Core code, offset +3.5
    logic regulator_on, sampling_on, convert_start, mute_to_analog, sign_to_analog; // Analog controls
    logic attenuator_on, single_ended_to_analog; // Analog controls
    logic [CHAN_W-1:0] channel_to_analog; // Channel
    logic [CODE_W-1:0] trim_pos_to_analog, trim_neg_to_analog; // Trims
    int fails = 0, compares = 0, starts = 0; // Counters
    logic [31:0] d; // Read value
    adc_offset_chop_delay_ctrl dut (.clk, .srst, .addr, .wdata, .we, .re, .rdata, .analog_code,
        .regulator_on, .sampling_on, .convert_start, .mute_to_analog, .sign_to_analog, .attenuator_on,
        .single_ended_to_analog, .channel_to_analog, .trim_pos_to_analog, .trim_neg_to_analog);
    // Clock, 100 ns period
    initial begin
        forever #50 clk = ~clk;
    end
    // Count start pulses
    always @(posedge clk) begin
        if (convert_start === 1'b1) starts++;
    end
    task automatic give_verdict();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask : bus_write
    task automatic bus_read(input logic [ADDR_W-1:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 v = rdata;
    endtask : bus_read
    task automatic expect_reg(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        logic [31:0] v;
        bus_read(a, v);
        check(v, e);
    endtask : expect_reg
    // Poll until the trigger bit drops
    task automatic wait_done();
        logic [31:0] v;
        for (int i = 0; i < 60; i++) begin
            bus_read(OFF_CONTROL_MAIN, v);
            if (v[BIT_TRIGGER] === 1'b0) return;
        end
        fails++;
        give_verdict();
    endtask : wait_done
    task automatic t_reset();
        expect_reg(OFF_TRIM_POS, 32'h200);
        expect_reg(OFF_TRIM_NEG, 32'h200);
        expect_reg(OFF_RESULT, 32'h200);
        expect_reg(OFF_CHOP_SUM, 32'h3FF);
        expect_reg(OFF_DELAY_A, 32'h000A_0000);
        expect_reg(OFF_DELAY_B, 32'h14);
        expect_reg(8'h40, 32'h0);
        bus_write(OFF_TRIM_POS, 32'hFFFF_F3FF);
        expect_reg(OFF_TRIM_POS, 32'h3FF);
        check(32'(trim_pos_to_analog), 32'h3FF);
        bus_write(OFF_TRIM_NEG, 32'h300); // 0.3 V common mode
        bus_write(OFF_TRIM_POS, 32'h300);
        expect_reg(OFF_TRIM_NEG, 32'h300);
        bus_write(OFF_TRIM_NEG, 32'h200); // 0.6 V baseline for calibration
        bus_write(OFF_TRIM_POS, 32'h200);
    endtask : t_reset
    task automatic t_convert();
        bus_write(OFF_CONTROL_MAIN, 32'h13); // Muted, sign 0, regulator on
        repeat (200) @(posedge clk); // 20 us regulator settling
        check(32'(mute_to_analog), 32'h1);
        check(32'(regulator_on), 32'h1);
        starts = 0;
        bus_write(OFF_CONTROL_MAIN, 32'h17);
        wait_done();
        check(32'(starts), 32'h1);
        expect_reg(OFF_RESULT, 32'h203);
        expect_reg(OFF_CONTROL_MAIN, 32'h13);
        bus_write(OFF_CONTROL_MAIN, 32'h33);
        bus_write(OFF_CONTROL_MAIN, 32'h37);
        wait_done();
        expect_reg(OFF_RESULT, 32'h1FC);
        check(32'(sign_to_analog), 32'h1);
        bus_write(OFF_TRIM_POS, 32'h1FD); // Differential: 0x200 minus +3
        bus_write(OFF_TRIM_NEG, 32'h204); // Differential: 0x200 minus -4
        expect_reg(OFF_TRIM_POS, 32'h1FD);
        check(32'(trim_neg_to_analog), 32'h204);
    endtask : t_convert
    task automatic t_chop();
        bus_write(OFF_CONTROL_MAIN, 32'h0A);
        starts = 0;
        bus_write(OFF_CONTROL_MAIN, 32'h0E);
        wait_done();
        check(32'(starts), 32'h2);
        expect_reg(OFF_CHOP_SUM, 32'h3FF);
        expect_reg(OFF_RESULT, 32'h1FF);
    endtask : t_chop
    task automatic t_battery();
        bus_write(OFF_CONTROL_SECOND, 32'h0);
        bus_write(OFF_CONTROL_MAIN, 32'h440);
        expect_reg(OFF_CONTROL_SECOND, 32'h1);
        check(32'(attenuator_on), 32'h1);
        check(32'(channel_to_analog), 32'h4);
        check(32'(single_ended_to_analog), 32'h1);
        repeat (10) @(posedge clk);
        expect_reg(OFF_STATUS, 32'h4); // Settled after 1 us, idle
        bus_write(OFF_CONTROL_MAIN, 32'h100);
        expect_reg(OFF_CONTROL_SECOND, 32'h0);
        check(32'(attenuator_on), 32'h0);
    endtask : t_battery
    task automatic t_delay();
        int n;
        bus_write(OFF_CONTROL_MAIN, 32'h0);
        bus_write(OFF_DELAY_A, 32'h0003_0002);
        bus_write(OFF_DELAY_B, 32'h5);
        bus_write(OFF_CONTROL_SECOND, 32'h2);
        bus_write(OFF_CONTROL_MAIN, 32'h7);
        n = 0;
        #1;
        while (convert_start !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1 n++;
        end
        check(32'(n >= 5 && n < 100), 32'h1);
        check(32'(regulator_on), 32'h1);
        wait_done();
        bus_read(OFF_STATUS, d);
        check(32'(d[24:16] != 9'h000), 32'h1);
        bus_write(OFF_CONTROL_SECOND, 32'h0);
        bus_read(OFF_STATUS, d);
        check(32'(d[24:16]), 32'h0);
        expect_reg(OFF_CONTROL_SECOND, 32'h0);
    endtask : t_delay
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset();
        t_convert(); // Calibration at start-up
        t_chop();
        t_battery();
        t_delay();
        give_verdict();
    end
endmodule : adc_offset_chop_delay_ctrl_bench
